// File: rtl/sra_pkg.sv
// constants shared by the status reporting aggregator
package sra_pkg;

	localparam int WIDE_W   = 16;
	localparam int NARROW_W = 8;
	localparam int NGRP     = 4;
	localparam int NPIN     = 10;

	// group indices
	localparam logic [1:0] G_NA = 2'h0;
	localparam logic [1:0] G_SQ = 2'h1;
	localparam logic [1:0] G_SE = 2'h2;
	localparam logic [1:0] G_SR = 2'h3;

	// register selectors within a group
	localparam logic [1:0] SEL_COND = 2'h0;
	localparam logic [1:0] SEL_EVT  = 2'h1;
	localparam logic [1:0] SEL_ENA  = 2'h2;

	// pin indices
	localparam int PIN_WAIT  = 0;
	localparam int PIN_CV    = 1;
	localparam int PIN_CC    = 2;
	localparam int PIN_PROG  = 3;
	localparam int PIN_FAULT = 4;
	localparam int NFAULT    = 6;

	// normal activity bit positions, and the used-bit masks of the activity and quality groups
	localparam int NA_WAIT_BIT = 5;
	localparam int NA_CV_BIT   = 8;
	localparam int NA_CC_BIT   = 10;
	localparam int NA_PROG_BIT = 14;
	localparam logic [15:0] NA_USED = 16'h4520;
	localparam logic [15:0] SQ_USED = 16'h003F;

	// status byte bit positions
	localparam int SB_SQ_BIT   = 3;
	localparam int SB_MSG_BIT  = 4;
	localparam int SB_SE_BIT   = 5;
	localparam int SB_RQS_BIT  = 6;
	localparam int SB_NA_BIT   = 7;

	// reset values
	localparam logic [15:0] ENA_RST = 16'h0000;
	localparam logic [15:0] EVT_RST = 16'h0000;
	localparam logic [7:0]  STB_RST = 8'h00;

endpackage : sra_pkg

// File: rtl/sra_grp_if.sv
// bundle between the aggregator top and one register group
`timescale 1ns/100ps
interface sra_grp_if #(parameter int W = 16);
	logic [W-1:0] cond;
	logic         en_wr;
	logic [W-1:0] en_data;
	logic         rd_clr;
	logic [W-1:0] evt;
	logic [W-1:0] ena;
	logic         summary;

	modport grp (input cond, en_wr, en_data, rd_clr, output evt, ena, summary);
	modport ctl (output cond, en_wr, en_data, rd_clr, input evt, ena, summary);
endinterface : sra_grp_if

// File: rtl/sra_group.sv
// one condition group: edge detect, event latch, enable mask
`timescale 1ns/100ps
module sra_group
	import sra_pkg::*;
#(
	parameter int W = WIDE_W
)
(
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// group bundle
	sra_grp_if.grp    gp
);

	typedef struct packed {
		logic [W-1:0] cond_r;
		logic [W-1:0] evt;
		logic [W-1:0] ena;
	} sra_grp_st_t;

	sra_grp_st_t  st_r;
	sra_grp_st_t  st_nxt;
	logic [W-1:0] rise;

	//////////////////////////////////////////////////////////////////////
	always_comb
	begin
		rise = gp.cond & ~st_r.cond_r;
		st_nxt = st_r;
		st_nxt.cond_r = gp.cond;
		// new edge wins over the read clear in the same cycle
		st_nxt.evt = (gp.rd_clr ? '0 : st_r.evt) | (rise & st_r.ena);
		if (gp.en_wr)
		begin
			st_nxt.ena = gp.en_data;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			st_r.cond_r <= '0;
			st_r.evt    <= EVT_RST[W-1:0];
			st_r.ena    <= ENA_RST[W-1:0];
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign gp.evt     = st_r.evt;
	assign gp.ena     = st_r.ena;
	assign gp.summary = |st_r.evt;

	//////////////////////////////////////////////////////////////////////
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_evt_sets: assert property ((rise & st_r.ena) != '0 |=>
		(gp.evt & $past(rise & st_r.ena)) == $past(rise & st_r.ena))
		else $error("enabled rising edge not latched");
	a_evt_masked: assert property ((gp.evt & ~$past(gp.evt)) ==
		(gp.evt & ~$past(gp.evt) & $past(rise & st_r.ena)))
		else $error("event bit set without enabled edge");
	a_read_clears: assert property (gp.rd_clr && (rise & st_r.ena) == '0 |=>
		gp.evt == '0)
		else $error("event read did not clear");

endmodule : sra_group

// File: rtl/sra_top.sv
// status reporting aggregator: pin sync, four groups, status byte, SRQ
`timescale 1ns/100ps
module sra_top
	import sra_pkg::*;
(
	// clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst_n,
	// normal activity pins
	input  wire logic                wait_trig,
	input  wire logic                cv_mode,
	input  wire logic                cc_mode,
	input  wire logic                prog_running,
	// signal quality fault pins
	input  wire logic                ov_fault,
	input  wire logic                oc_fault,
	input  wire logic                sense_fault,
	input  wire logic                thermal_fault,
	input  wire logic                mains_fault,
	input  wire logic                fan_fault,
	// same-clock sources from the command handler
	input  wire logic [NARROW_W-1:0] std_event_cond,
	input  wire logic                err_queue_busy,
	input  wire logic                msg_waiting,
	// command access port
	input  wire logic                cmd_rd,
	input  wire logic                cmd_wr,
	input  wire logic [1:0]          cmd_grp,
	input  wire logic [1:0]          cmd_reg,
	input  wire logic [WIDE_W-1:0]   cmd_wdata,
	output logic      [WIDE_W-1:0]   rd_data,
	output logic                     rd_valid,
	output logic                     rd_err,
	// serial poll and service request
	output logic      [7:0]          status_byte,
	output logic                     srq
);

	typedef struct packed {
		logic [NPIN-1:0]   s0;
		logic [NPIN-1:0]   s1;
		logic [NPIN-1:0]   s2;
		logic [NPIN-1:0]   pin;
		logic [7:0]        stb;
		logic              srq;
		logic [WIDE_W-1:0] rdata;
		logic              rvalid;
		logic              rerr;
	} sra_top_st_t;

	sra_top_st_t st_r;
	sra_top_st_t st_nxt;

	logic [NPIN-1:0]                pins_raw;
	logic [NGRP-1:0][WIDE_W-1:0]    cond_w;
	logic [NGRP-1:0][WIDE_W-1:0]    evt_w;
	logic [NGRP-1:0][WIDE_W-1:0]    ena_w;
	logic [NGRP-1:0]                sum_w;
	logic [NGRP-1:0]                clr_w;
	logic [NGRP-1:0]                enwr_w;
	logic [WIDE_W-1:0]              na_cond;
	logic [WIDE_W-1:0]              sq_cond;
	logic [7:0]                     sb_cond;
	logic                           rqs;

	//////////////////////////////////////////////////////////////////////
	// pin gathering
	assign pins_raw[PIN_WAIT]      = wait_trig;
	assign pins_raw[PIN_CV]        = cv_mode;
	assign pins_raw[PIN_CC]        = cc_mode;
	assign pins_raw[PIN_PROG]      = prog_running;
	assign pins_raw[PIN_FAULT]     = ov_fault;
	assign pins_raw[PIN_FAULT + 1] = oc_fault;
	assign pins_raw[PIN_FAULT + 2] = sense_fault;
	assign pins_raw[PIN_FAULT + 3] = thermal_fault;
	assign pins_raw[PIN_FAULT + 4] = mains_fault;
	assign pins_raw[PIN_FAULT + 5] = fan_fault;

	//////////////////////////////////////////////////////////////////////
	// condition vectors
	always_comb
	begin
		na_cond = '0;
		na_cond[NA_WAIT_BIT] = st_r.pin[PIN_WAIT];
		na_cond[NA_CV_BIT]   = st_r.pin[PIN_CV];
		na_cond[NA_CC_BIT]   = st_r.pin[PIN_CC];
		na_cond[NA_PROG_BIT] = st_r.pin[PIN_PROG];
	end

	always_comb
	begin
		sq_cond = '0;
		// bits 0..5: overvoltage, overcurrent, sense, thermal, mains, fan
		sq_cond[NFAULT-1:0] = st_r.pin[PIN_FAULT +: NFAULT];
	end

	//////////////////////////////////////////////////////////////////////
	// status byte, the service request group's condition
	always_comb
	begin
		sb_cond = '0;
		// error queue and quality summary share bit 3
		sb_cond[SB_SQ_BIT]  = sum_w[G_SQ] | err_queue_busy;
		sb_cond[SB_MSG_BIT] = msg_waiting;
		sb_cond[SB_SE_BIT]  = sum_w[G_SE];
		sb_cond[SB_NA_BIT]  = sum_w[G_NA];
		// enable bit 6 is stored but never gates its own result
		rqs = |(sb_cond & ena_w[G_SR][7:0] & ~(8'h01 << SB_RQS_BIT));
		sb_cond[SB_RQS_BIT] = rqs;
	end

	assign cond_w[G_NA] = na_cond;
	assign cond_w[G_SQ] = sq_cond;
	assign cond_w[G_SE] = WIDE_W'(std_event_cond);
	assign cond_w[G_SR] = WIDE_W'(sb_cond);

	//////////////////////////////////////////////////////////////////////
	// the four groups
	genvar g;
	generate
		for (g = 0; g < NGRP; g++)
		begin : gen_grp
			localparam int GW = (g < 2) ? WIDE_W : NARROW_W;

			sra_grp_if #(.W(GW)) gi ();

			assign clr_w[g]  = cmd_rd && cmd_grp == 2'(g) && cmd_reg == SEL_EVT;
			assign enwr_w[g] = cmd_wr && cmd_grp == 2'(g) && cmd_reg == SEL_ENA;

			assign gi.cond    = cond_w[g][GW-1:0];
			assign gi.en_wr   = enwr_w[g];
			assign gi.en_data = cmd_wdata[GW-1:0];
			assign gi.rd_clr  = clr_w[g];
			assign evt_w[g]   = WIDE_W'(gi.evt);
			assign ena_w[g]   = WIDE_W'(gi.ena);
			assign sum_w[g]   = gi.summary;

			sra_group #(.W(GW)) u_group (
				.sys_clk (sys_clk),
				.rst_n   (rst_n),
				.gp      (gi.grp)
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		st_nxt = st_r;
		// third stage gives the value once the second agrees; first stage feeds nothing else
		st_nxt.s0 = pins_raw;
		st_nxt.s1 = st_r.s0;
		st_nxt.s2 = st_r.s1;
		for (int i = 0; i < NPIN; i++)
		begin
			if (st_r.s1[i] == st_r.s2[i])
			begin
				st_nxt.pin[i] = st_r.s2[i];
			end
		end

		st_nxt.stb = sb_cond;
		st_nxt.srq = rqs;

		st_nxt.rvalid = cmd_rd;
		st_nxt.rerr   = 1'b0;
		if (cmd_rd)
		begin
			case (cmd_reg)
				SEL_COND: st_nxt.rdata = cond_w[cmd_grp];
				SEL_EVT:  st_nxt.rdata = evt_w[cmd_grp];
				SEL_ENA:  st_nxt.rdata = ena_w[cmd_grp];
				default:
				begin
					st_nxt.rdata = '0;
					st_nxt.rerr  = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			st_r.s0     <= '0;
			st_r.s1     <= '0;
			st_r.s2     <= '0;
			st_r.pin    <= '0;
			st_r.stb    <= STB_RST;
			st_r.srq    <= 1'b0;
			st_r.rdata  <= '0;
			st_r.rvalid <= 1'b0;
			st_r.rerr   <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// outputs
	assign rd_data     = st_r.rdata;
	assign rd_valid    = st_r.rvalid;
	assign rd_err      = st_r.rerr;
	assign status_byte = st_r.stb;
	assign srq         = st_r.srq;

	//////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	logic rd_na_cond;
	logic rd_sq_cond;
	logic rd_narrow;
	logic rd_sr_cond;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			rd_na_cond <= 1'b0;
			rd_sq_cond <= 1'b0;
			rd_narrow  <= 1'b0;
			rd_sr_cond <= 1'b0;
		end
		else
		begin
			rd_na_cond <= cmd_rd && cmd_grp == G_NA && cmd_reg == SEL_COND;
			rd_sq_cond <= cmd_rd && cmd_grp == G_SQ && cmd_reg == SEL_COND;
			rd_narrow  <= cmd_rd && cmd_grp[1];
			rd_sr_cond <= cmd_rd && cmd_grp == G_SR && cmd_reg == SEL_COND;
		end
	end

	a_width_narrow: assert property (rd_narrow |-> rd_data[15:8] == 8'h00)
		else $error("narrow group read has upper bits set");

	a_summary_na: assert property (evt_w[G_NA] != '0 |=> status_byte[SB_NA_BIT])
		else $error("activity summary missing from status byte");

	a_quality_bit3: assert property (sum_w[G_SQ] |=> status_byte[SB_SQ_BIT])
		else $error("quality summary not in status byte bit 3");

	a_errq_bit3: assert property (err_queue_busy |=> status_byte[SB_SQ_BIT])
		else $error("error queue not reflected in bit 3");

	a_msg_bit4: assert property (msg_waiting |=> status_byte[SB_MSG_BIT])
		else $error("message waiting not in bit 4");

	a_rqs_value: assert property (##1 status_byte[SB_RQS_BIT] ==
		|($past(sb_cond) & $past(ena_w[G_SR][7:0]) & 8'hBF))
		else $error("request summary bit 6 wrong");

	a_srq_level: assert property (srq == status_byte[SB_RQS_BIT])
		else $error("SRQ does not follow bit 6");

	a_na_unused: assert property (rd_na_cond |-> (rd_data & ~NA_USED) == '0)
		else $error("unused activity bit reads one");

	a_na_wait: assert property (rd_na_cond |->
		rd_data[NA_WAIT_BIT] == $past(st_r.pin[PIN_WAIT]))
		else $error("waiting for trigger bit wrong");

	a_sq_unused: assert property (rd_sq_cond |-> (rd_data & ~SQ_USED) == '0)
		else $error("unused quality bit reads one");

	a_sq_fault: assert property (rd_sq_cond |->
		rd_data[NFAULT-1:0] == $past(st_r.pin[PIN_FAULT +: NFAULT]))
		else $error("quality fault bits wrong");

	a_pin_sync: assert property ($changed(st_r.pin) |->
		$past(st_r.s1 == st_r.s2))
		else $error("pin accepted before stages agreed");

	a_read_answer: assert property (cmd_rd |=> rd_valid)
		else $error("read got no answer");

	a_na_modes: assert property (rd_na_cond |->
		rd_data[NA_CV_BIT] == $past(st_r.pin[PIN_CV]) &&
		rd_data[NA_CC_BIT] == $past(st_r.pin[PIN_CC]))
		else $error("regulation mode bits wrong");

	a_na_prog: assert property (rd_na_cond |->
		rd_data[NA_PROG_BIT] == $past(st_r.pin[PIN_PROG]))
		else $error("program running bit wrong");

	a_na_bit0: assert property (rd_na_cond |-> !rd_data[0])
		else $error("activity bit 0 reads one");

	a_sr_cond_read: assert property (rd_sr_cond |->
		rd_data == {8'h00, $past(sb_cond)})
		else $error("request condition read differs from status");

	// writes land on the next edge; narrow groups drop the upper byte
	a_ena_write_na: assert property (
		cmd_wr && cmd_grp == G_NA && cmd_reg == SEL_ENA |=> ena_w[G_NA] == $past(cmd_wdata))
		else $error("activity enable write lost");

	a_ena_write_sr: assert property (
		cmd_wr && cmd_grp == G_SR && cmd_reg == SEL_ENA |=>
		ena_w[G_SR] == {8'h00, $past(cmd_wdata[7:0])})
		else $error("request enable write wrong");

	a_rd_pulse: assert property (rd_valid |-> $past(cmd_rd))
		else $error("read answer without a request");

	a_rd_refused: assert property (rd_err |->
		rd_valid && rd_data == '0 && $past(cmd_reg) == 2'h3)
		else $error("unmapped read answered wrongly");

	// data stays put between reads so a slow host can still take it
	a_rd_hold: assert property (!cmd_rd |=> $stable(rd_data))
		else $error("read data moved without a read");

	a_stb_low_zero: assert property (status_byte[2:0] == 3'h0)
		else $error("unused status byte bit set");

	a_se_summary: assert property (evt_w[G_SE] != '0 |=> status_byte[SB_SE_BIT])
		else $error("standard event summary missing");

	a_na_cause: assert property (status_byte[SB_NA_BIT] |-> $past(evt_w[G_NA] != '0))
		else $error("activity summary without an event");

	a_bit3_exact: assert property (##1 status_byte[SB_SQ_BIT] ==
		$past(sum_w[G_SQ] | err_queue_busy))
		else $error("status byte bit 3 wrong");

	a_msg_exact: assert property (##1 status_byte[SB_MSG_BIT] == $past(msg_waiting))
		else $error("status byte bit 4 wrong");

	a_srq_needs_ena: assert property (srq |->
		$past(ena_w[G_SR][7:0] & 8'hBF) != '0)
		else $error("SRQ raised with no enabled cause");

	//////////////////////////////////////////////////////////////////////
	// main scenarios
	c_srq_raised: cover property ($rose(srq));
	c_evt_cleared: cover property (clr_w[G_SQ] && evt_w[G_SQ] != '0 ##1 evt_w[G_SQ] == '0);
	c_fault_seen: cover property ($rose(st_r.pin[PIN_FAULT]) ##[1:4] sum_w[G_SQ]);
	c_bad_select: cover property (rd_err);
	c_set_wins: cover property (clr_w[G_SE] ##1 evt_w[G_SE] != '0);

endmodule : sra_top

// File: tb/sra_host_model.sv
// host controller model: serial polls the device when it asks for service
`timescale 1ns/100ps
module sra_host_model
(
	// clock
	input  wire logic       sys_clk,
	// device side
	input  wire logic       srq,
	input  wire logic [7:0] status_byte,
	// poll results
	output logic      [7:0] poll_byte,
	output logic      [7:0] poll_cnt
);
	logic srq_q = 1'b0;
	initial poll_byte = 8'h00;
	initial poll_cnt = 8'h00;
	// one poll per new request; the line stays up until its cause clears
	always @(posedge sys_clk)
	begin
		srq_q <= srq;
		if (srq && !srq_q)
		begin
			poll_byte <= status_byte;
			poll_cnt  <= poll_cnt + 8'h01;
		end
	end
endmodule : sra_host_model

// File: tb/tb_top.sv
// self-checking bench for the status reporting aggregator
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top
	import sra_pkg::*;
;
	logic        sys_clk, rst_n, cmd_rd, cmd_wr, err_queue_busy, msg_waiting;
	logic        rd_valid, rd_err, srq, gerr;
	logic [9:0]  pins;
	logic [7:0]  std_event_cond, status_byte, poll_byte, poll_cnt;
	logic [1:0]  cmd_grp, cmd_reg;
	logic [15:0] cmd_wdata, rd_data, got;
	int          n_mismatch = 0;
	int          check_count = 0;
	int          cyc = 0;
	typedef struct packed { logic [9:0] p; logic [1:0] g; logic [15:0] e; } sra_row_t;
	// pins: fan mains thermal sense oc ov prog cc cv wait
	sra_row_t rows [8] = '{
		'{10'h001, G_NA, 16'h0020}, '{10'h002, G_NA, 16'h0100},
		'{10'h004, G_NA, 16'h0400}, '{10'h008, G_NA, 16'h4000},
		'{10'h00F, G_NA, 16'h4520}, '{10'h3F0, G_SQ, 16'h003F},
		'{10'h010, G_SQ, 16'h0001}, '{10'h200, G_SQ, 16'h0020}};
	////////////////////////////////////////////////////////////////////////////
	sra_top u_sra_top (.sys_clk(sys_clk), .rst_n(rst_n), .wait_trig(pins[0]),
		.cv_mode(pins[1]), .cc_mode(pins[2]), .prog_running(pins[3]),
		.ov_fault(pins[4]), .oc_fault(pins[5]), .sense_fault(pins[6]),
		.thermal_fault(pins[7]), .mains_fault(pins[8]), .fan_fault(pins[9]),
		.std_event_cond(std_event_cond), .err_queue_busy(err_queue_busy),
		.msg_waiting(msg_waiting), .cmd_rd(cmd_rd), .cmd_wr(cmd_wr),
		.cmd_grp(cmd_grp), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata),
		.rd_data(rd_data), .rd_valid(rd_valid), .rd_err(rd_err),
		.status_byte(status_byte), .srq(srq));
	sra_host_model u_sra_host_model (.sys_clk(sys_clk), .srq(srq),
		.status_byte(status_byte), .poll_byte(poll_byte), .poll_cnt(poll_cnt));
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// hang guard, far above the roughly 170 cycles the run needs
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	// read; an idle cycle after keeps strobes from being set twice at one edge
	task automatic rd(input logic [1:0] g, input logic [1:0] r);
		cmd_grp = g;
		cmd_reg = r;
		cmd_rd = 1'b1;
		@(negedge sys_clk);
		cmd_rd = 1'b0;
		`CHK(rd_valid, 1'b1)
		got = rd_data;
		gerr = rd_err;
		@(negedge sys_clk);
	endtask : rd
	task automatic wr(input logic [1:0] g, input logic [15:0] d);
		cmd_grp = g;
		cmd_reg = SEL_ENA;
		cmd_wdata = d;
		cmd_wr = 1'b1;
		@(negedge sys_clk);
		cmd_wr = 1'b0;
		@(negedge sys_clk);
	endtask : wr
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		rst_n = 1'b0;
		cmd_rd = 1'b0;
		cmd_wr = 1'b0;
		cmd_grp = 2'h0;
		cmd_reg = 2'h0;
		cmd_wdata = 16'h0000;
		pins = 10'h000;
		std_event_cond = 8'h00;
		err_queue_busy = 1'b0;
		msg_waiting = 1'b0;
		repeat (4) @(negedge sys_clk);
		rst_n = 1'b1;
		`CHK(status_byte, 8'h00)
		`CHK(srq, 1'b0)
		rd(G_SQ, SEL_ENA);
		`CHK(got, 16'h0000)
		$display("test reset done");
		foreach (rows[i])
		begin
			pins = rows[i].p;
			repeat (8) @(negedge sys_clk);
			rd(rows[i].g, SEL_COND);
			`CHK(got, rows[i].e)
		end
		// all enables off, so none of those rises may be latched
		`CHK(status_byte, 8'h00)
		pins = 10'h000;
		repeat (8) @(negedge sys_clk);
		$display("test conditions done");
		wr(G_SQ, 16'h0001);
		wr(G_SR, 16'h0008);
		wr(G_SE, 16'hFFFF);
		rd(G_SE, SEL_ENA);
		`CHK(got, 16'h00FF)
		pins[4] = 1'b1;
		repeat (8) @(negedge sys_clk);
		`CHK(status_byte, 8'h48)
		`CHK(srq, 1'b1)
		`CHK(poll_byte, 8'h48)
		rd(G_SQ, SEL_EVT);
		`CHK(got, 16'h0001)
		rd(G_SQ, SEL_EVT);
		`CHK(got, 16'h0000)
		`CHK(status_byte, 8'h00)
		`CHK(srq, 1'b0)
		$display("test event and request done");
		// rise while masked, then unmask: no late latch
		pins[5] = 1'b1;
		repeat (8) @(negedge sys_clk);
		wr(G_SQ, 16'h0003);
		repeat (3) @(negedge sys_clk);
		rd(G_SQ, SEL_EVT);
		`CHK(got, 16'h0000)
		$display("test masked edge done");
		err_queue_busy = 1'b1;
		msg_waiting = 1'b1;
		repeat (4) @(negedge sys_clk);
		`CHK(status_byte, 8'h58)
		`CHK(poll_cnt, 8'h02)
		err_queue_busy = 1'b0;
		msg_waiting = 1'b0;
		$display("test queue and message done");
		wr(G_NA, 16'h0020);
		pins[0] = 1'b1;
		std_event_cond = 8'h01;
		repeat (8) @(negedge sys_clk);
		// summaries not in the request mask must not raise the line
		`CHK(status_byte, 8'hA0)
		rd(G_SE, SEL_EVT);
		`CHK(got, 16'h0001)
		rd(G_NA, 2'h3);
		`CHK(gerr, 1'b1)
		`CHK(got, 16'h0000)
		$display("test summaries done");
		std_event_cond = 8'h00;
		@(negedge sys_clk);
		// rise and read clear in one cycle: the new event survives
		std_event_cond = 8'h02;
		rd(G_SE, SEL_EVT);
		`CHK(got, 16'h0000)
		rd(G_SE, SEL_EVT);
		`CHK(got, 16'h0002)
		$display("test set over clear done");
		// reset in mid-run with pins and standard events still high
		rst_n = 1'b0;
		repeat (2) @(negedge sys_clk);
		rst_n = 1'b1;
		`CHK(status_byte, 8'h00)
		`CHK(srq, 1'b0)
		rd(G_NA, SEL_EVT);
		`CHK(got, 16'h0000)
		rd(G_SE, SEL_ENA);
		`CHK(got, 16'h0000)
		repeat (8) @(negedge sys_clk);
		// enables came back zero, so the re-synced rises stay unlatched
		`CHK(status_byte, 8'h00)
		rd(G_NA, SEL_COND);
		`CHK(got, 16'h0020)
		$display("test reset in run done");
		close_out();
	end
endmodule : tb_top
